// ### src/muxed_external_memory_interface.v
// multiplexed external memory interface: config register and bus phases
`timescale 1ns/1ps
`default_nettype none
`include "emif_defs.vh"
module muxed_external_memory_interface (
  // clock and reset
  input wire clock,
  input wire resetn,
  // special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  // core access request
  input wire acc_req,
  input wire acc_we,
  input wire acc_8bit,
  input wire [15:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [7:0] external_data_ram_page_select,
  input wire [7:0] port_latch_high,
  output reg acc_busy_r,
  output reg acc_done_r,
  output reg acc_onchip_r,
  output reg [10:0] onchip_addr_r,
  output reg [7:0] acc_rdata_r,
  // memory pins
  input wire [7:0] ad_in,
  output reg [7:0] ad_out_r,
  output reg ad_oen_r,
  output reg [7:0] addr_high_r,
  output reg addr_high_oen_r,
  output reg ale_r,
  output reg rd_n_r,
  output reg wr_n_r,
  output reg emif_owns_pins_r
);
  ////////////////////////////////////////////////////////////////////////
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ALE_HI = 5'h02;
  localparam [4:0] S_ALE_LO = 5'h04;
  localparam [4:0] S_STROBE = 5'h08;
  localparam [4:0] S_HOLD = 5'h10;

  reg [3:0] cfg_r;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [1:0] mode_r;
  reg [1:0] ale_w_r;
  reg we_r;
  reg [7:0] data_r;
  reg [7:0] lo_r;
  reg tload;
  reg [3:0] tcount;
  wire tdone;
  wire off_chip;
  wire drive_high;

  function [3:0] width_of;
    input [1:0] sel;
    begin
      width_of = {2'b00, sel} + `CNT_ONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // config register: low four bits stored only
  always @(posedge clock)
  begin
    if (!resetn)
      cfg_r <= 4'h3;
    else if (sfr_wr && sfr_addr == `CFG_ADDR)
      cfg_r <= sfr_wdata[3:0];
  end

  always @(posedge clock)
  begin
    if (!resetn)
      sfr_rdata_r <= 8'h00;
    else if (sfr_addr == `CFG_ADDR)
      sfr_rdata_r <= {4'h0, cfg_r};
    else
      sfr_rdata_r <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  access_router u_router (
    .mode(cfg_r[`MODE_HI:`MODE_LO]),
    .is_8bit(acc_8bit),
    .eff_addr(acc_addr),
    .off_chip(off_chip),
    .drive_high(drive_high)
  );

  phase_timer u_timer (
    .clock(clock),
    .resetn(resetn),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  ////////////////////////////////////////////////////////////////////////
  // with config bit three set (modes 10 and 11) the width field is ignored
  wire [1:0] ale_sel;
  assign ale_sel = cfg_r[`MODE_HI] ? `ALE_DEFAULT :
                   cfg_r[`ALE_HI:`ALE_LO];

  always @*
  begin
    state_nxt = state_r;
    tload = 1'b0;
    tcount = 4'h0;
    case (state_r)
      S_IDLE:
      begin
        if (acc_req && off_chip)
        begin
          state_nxt = S_ALE_HI;
          tload = 1'b1;
          tcount = width_of(ale_sel);
        end
      end
      S_ALE_HI:
      begin
        if (tdone)
        begin
          state_nxt = S_ALE_LO;
          tload = 1'b1;
          tcount = width_of(ale_w_r);
        end
      end
      S_ALE_LO:
      begin
        if (tdone)
        begin
          state_nxt = S_STROBE;
          tload = 1'b1;
          // strobe takes the fixed overhead, minus the one hold cycle
          tcount = `EXTRA_CYCLES - `CNT_ONE;
        end
      end
      S_STROBE:
      begin
        if (tdone)
        begin
          state_nxt = S_HOLD;
          tload = 1'b1;
          tcount = `HOLD_CYCLES;
        end
      end
      S_HOLD:
      begin
        if (tdone)
          state_nxt = S_IDLE;
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      mode_r <= `MODE_INT;
      ale_w_r <= 2'h0;
      we_r <= 1'b0;
      data_r <= 8'h00;
      lo_r <= 8'h00;
      acc_busy_r <= 1'b0;
      acc_done_r <= 1'b0;
      acc_onchip_r <= 1'b0;
      onchip_addr_r <= 11'h000;
      acc_rdata_r <= 8'h00;
      ad_out_r <= 8'hFF;
      ad_oen_r <= 1'b1;
      addr_high_r <= 8'hFF;
      addr_high_oen_r <= 1'b1;
      ale_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      emif_owns_pins_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      acc_done_r <= 1'b0;
      acc_onchip_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (acc_req && !off_chip)
          begin
            // on-chip: address wraps onto the 2 kB space
            acc_onchip_r <= 1'b1;
            onchip_addr_r <= acc_addr[10:0];
            acc_done_r <= 1'b1;
          end
          else if (acc_req)
          begin
            // snapshot config so later writes wait for next access
            mode_r <= cfg_r[`MODE_HI:`MODE_LO];
            ale_w_r <= ale_sel;
            we_r <= acc_we;
            data_r <= acc_wdata;
            lo_r <= acc_addr[7:0];
            acc_busy_r <= 1'b1;
            emif_owns_pins_r <= 1'b1;
            ale_r <= 1'b1;
            ad_out_r <= acc_addr[7:0];
            ad_oen_r <= 1'b0;
            addr_high_oen_r <= ~drive_high;
            if (!drive_high)
              addr_high_r <= port_latch_high;
            else if (acc_8bit)
              addr_high_r <= external_data_ram_page_select;
            else
              addr_high_r <= acc_addr[15:8];
          end
        end
        S_ALE_HI:
          if (tdone)
            ale_r <= 1'b0;
        S_ALE_LO:
        begin
          if (tdone)
          begin
            rd_n_r <= we_r;
            wr_n_r <= ~we_r;
            ad_out_r <= data_r;
            ad_oen_r <= ~we_r;
          end
        end
        S_STROBE:
        begin
          if (tdone)
          begin
            if (!we_r)
              acc_rdata_r <= ad_in;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
          end
        end
        S_HOLD:
        begin
          if (tdone)
          begin
            acc_busy_r <= 1'b0;
            acc_done_r <= 1'b1;
            emif_owns_pins_r <= 1'b0;
            ad_oen_r <= 1'b1;
            addr_high_oen_r <= 1'b1;
          end
        end
        default:
          acc_busy_r <= 1'b0;
      endcase
    end
  end
endmodule // muxed_external_memory_interface
`default_nettype wire

// ### src/emif_defs.vh
// constants for the multiplexed external memory interface
// Operation
// - top three config bits read zero, writes ignored
// - bit four reads zero; software writes zero
// - mode 00 sends all accesses on-chip
// - mode 01 splits at 2 kB boundary
// - mode 01 8-bit high byte from port latch
// - mode 10 splits at 2 kB boundary
// - mode 10 8-bit high byte from page
// - mode 11 sends all accesses off-chip
// - strobe high and low width field+1 cycles
// - width field used only when config bit 3 zero
// - data and low address share eight pins
// - first phase strobe high, low address out
// - data takes pins when read/write asserted
// - pins claimed only during off-chip access
// - drivers disabled on pins acting as inputs
// - access lasts programmed timing plus four
`ifndef EMIF_DEFS_VH
`define EMIF_DEFS_VH
`define CFG_ADDR 8'hB2
`define CFG_RESET 8'h03
`define CFG_WMASK 8'h0F
`define MODE_HI 3
`define MODE_LO 2
`define ALE_HI 1
`define ALE_LO 0
`define MODE_INT 2'h0
`define MODE_SPLIT_NB 2'h1
`define MODE_SPLIT_BS 2'h2
`define MODE_EXT 2'h3
`define ONCHIP_TOP 5
`define ALE_DEFAULT 2'h0
`define EXTRA_CYCLES 4'h4
`define HOLD_CYCLES 4'h1
`define CNT_ONE 4'h1
`endif

// ### src/access_router.v
// routing decision for one external-move access
`timescale 1ns/1ps
`default_nettype none
`include "emif_defs.vh"
module access_router (
  // access
  input wire [1:0] mode,
  input wire is_8bit,
  input wire [15:0] eff_addr,
  // decision
  output reg off_chip,
  output reg drive_high
);
  wire above;
  // in the split modes anything with bits above 2 kB set lies off-chip
  assign above = |eff_addr[15:11];
  always @*
  begin
    off_chip = 1'b0;
    drive_high = 1'b1;
    case (mode)
      `MODE_INT:
      begin
        off_chip = 1'b0;
      end
      `MODE_SPLIT_NB:
      begin
        off_chip = above;
        drive_high = ~is_8bit;
      end
      `MODE_SPLIT_BS:
      begin
        off_chip = above;
        drive_high = 1'b1;
      end
      default:
      begin
        off_chip = 1'b1;
        drive_high = ~is_8bit;
      end
    endcase
  end
endmodule // access_router
`default_nettype wire

// ### src/phase_timer.v
// down-counter for bus phases
`timescale 1ns/1ps
`default_nettype none
`include "emif_defs.vh"
module phase_timer (
  // clock and reset
  input wire clock,
  input wire resetn,
  // control
  input wire load,
  input wire [3:0] count,
  // status
  output wire done
);
  reg [3:0] cnt_r;
  always @(posedge clock)
  begin
    if (!resetn)
      cnt_r <= 4'h0;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - `CNT_ONE;
  end
  assign done = (cnt_r == `CNT_ONE) || (cnt_r == 4'h0);
endmodule // phase_timer
`default_nettype wire

// ### sim/ext_mem.sv
// latch and byte-wide memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
  // bus pins
  input wire logic clock,
  input wire logic [7:0] ad_out,
  input wire logic ad_oen,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] ad_in
);
  logic [7:0] lat;
  logic [7:0] mem [0:255];
  always_latch
    if (ale)
      lat <= ad_out;
  always @(posedge clock)
    if (!wr_n)
      mem[lat] <= ad_out;
  // released bus shows inverted address, never a stale match
  assign ad_in = !ad_oen ? ad_out : (!rd_n ? mem[lat] : ~lat);
endmodule // ext_mem
`default_nettype wire

// ### sim/emif_asserts.sv
// assertions on the external memory interface ports
`timescale 1ns/1ps
`default_nettype none
module emif_asserts (
  // watched ports
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic [15:0] acc_addr,
  input wire logic acc_done_r,
  input wire logic acc_onchip_r,
  input wire logic [10:0] onchip_addr_r,
  input wire logic ad_oen_r,
  input wire logic addr_high_oen_r,
  input wire logic ale_r,
  input wire logic rd_n_r,
  input wire logic wr_n_r,
  input wire logic emif_owns_pins_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence wr_on;
    $fell(wr_n_r);
  endsequence
  sequence wr_held;
    !wr_n_r [*3] ##1 wr_n_r;
  endsequence
  cfg_upper_zero_a: assert property (sfr_rdata_r[7:4] == 4'h0)
    else $error("config upper bits not zero");
  onchip_alias_a: assert property (acc_onchip_r |-> acc_done_r
    && !emif_owns_pins_r && onchip_addr_r == $past(acc_addr[10:0]))
    else $error("on-chip access wrong");
  idle_release_a: assert property (!emif_owns_pins_r |-> ad_oen_r
    && addr_high_oen_r && rd_n_r && wr_n_r && !ale_r)
    else $error("pins held while idle");
  read_float_a: assert property (!rd_n_r |-> ad_oen_r)
    else $error("bus driven during read");
  write_drive_a: assert property (!wr_n_r |-> !ad_oen_r)
    else $error("bus not driven during write");
  write_len_a: assert property (wr_on |-> wr_held)
    else $error("write strobe length wrong");
  ale_addr_a: assert property (ale_r |-> !ad_oen_r && rd_n_r)
    else $error("address phase wrong");
  ale_fall_a: assert property ($fell(ale_r) |-> ##[1:4] !(rd_n_r && wr_n_r))
    else $error("no strobe after latch phase");
endmodule // emif_asserts
bind muxed_external_memory_interface emif_asserts chk_i (.clock, .resetn,
  .sfr_rdata_r, .acc_addr, .acc_done_r, .acc_onchip_r, .onchip_addr_r,
  .ad_oen_r, .addr_high_oen_r, .ale_r, .rd_n_r, .wr_n_r, .emif_owns_pins_r);
`default_nettype wire

// ### sim/test_muxed_external_memory_interface.sv
// self-checking bench for the external memory interface
`timescale 1ns/1ps
`default_nettype none
module test_muxed_external_memory_interface;
  logic clock, resetn, sfr_wr, acc_req, acc_we, acc_8bit, hoen;
  logic [7:0] sfr_addr, sfr_wdata, acc_wdata, sfr_rdata_r, ad_in, lo, hb;
  logic [7:0] external_data_ram_page_select, port_latch_high, acc_rdata_r;
  logic [7:0] ad_out_r, addr_high_r;
  logic [15:0] acc_addr;
  logic [10:0] onchip_addr_r;
  logic acc_busy_r, acc_done_r, acc_onchip_r, ad_oen_r, addr_high_oen_r;
  logic ale_r, rd_n_r, wr_n_r, emif_owns_pins_r;
  integer num_errors, tests_run, cyc, hi, bz, f;
  muxed_external_memory_interface DUT (.clock, .resetn, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rdata_r, .acc_req, .acc_we, .acc_8bit, .acc_addr,
    .acc_wdata, .external_data_ram_page_select, .port_latch_high, .acc_busy_r,
    .acc_done_r, .acc_onchip_r, .onchip_addr_r, .acc_rdata_r, .ad_in,
    .ad_out_r, .ad_oen_r, .addr_high_r, .addr_high_oen_r, .ale_r, .rd_n_r,
    .wr_n_r, .emif_owns_pins_r);
  ext_mem mem_i (.clock, .ad_out(ad_out_r), .ad_oen(ad_oen_r), .ale(ale_r),
    .rd_n(rd_n_r), .wr_n(wr_n_r), .ad_in);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // about two hundred cycles suffice; this cuts a hang
  initial
  begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input logic ok, input string m);
    begin
      tests_run = tests_run + 1;
      if (ok !== 1'b1)
      begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: %s", $time, m);
      end
    end
  endtask
  task wcfg(input logic [7:0] v);
    begin
      @(posedge clock);
      sfr_addr <= 8'hB2;
      sfr_wr <= 1'b1;
      sfr_wdata <= v;
      @(posedge clock);
      sfr_wr <= 1'b0;
    end
  endtask
  task rcfg(input logic [7:0] a, input logic [7:0] e);
    begin
      @(posedge clock);
      sfr_addr <= a;
      @(posedge clock);
      #1;
      chk(sfr_rdata_r === e, "config read");
    end
  endtask
  task acc(input logic we, input logic b8, input logic [15:0] a);
    begin
      @(posedge clock);
      acc_req <= 1'b1;
      acc_we <= we;
      acc_8bit <= b8;
      acc_addr <= a;
      // reads carry a different word, so a driven bus cannot fake read data
      acc_wdata <= we ? (a[7:0] ^ 8'hC3) : 8'h00;
      @(posedge clock);
      acc_req <= 1'b0;
      cyc = 0;
      hi = 0;
      bz = 0;
      while (acc_done_r !== 1'b1 && cyc < 40)
      begin
        #1;
        cyc = cyc + 1;
        if (ale_r === 1'b1)
        begin
          hi = hi + 1;
          hb = addr_high_r;
          hoen = addr_high_oen_r;
          lo = ad_out_r;
        end
        if (acc_busy_r === 1'b1)
          bz = bz + 1;
        if (acc_done_r !== 1'b1)
          @(posedge clock);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reg;
    begin
      rcfg(8'hB2, 8'h03);
      rcfg(8'h10, 8'h00);
      wcfg(8'hEF);
      rcfg(8'hB2, 8'h0F);
    end
  endtask
  task t_onchip;
    begin
      wcfg(8'h00);
      acc(1'b0, 1'b0, 16'h1234);
      chk(acc_onchip_r === 1'b1 && onchip_addr_r === 11'h234, "alias");
    end
  endtask
  task t_split;
    begin
      for (f = 0; f < 4; f = f + 1)
      begin
        wcfg(8'h04 + f[7:0]);
        acc(1'b1, 1'b0, 16'h1200 + f[15:0]);
        chk(hi === f + 1 && cyc === 2 * f + 7, "latch width");
        chk(lo === f[7:0] && hb === 8'h12, "address out");
        acc(1'b0, 1'b0, 16'h1200 + f[15:0]);
        chk(acc_rdata_r === (f[7:0] ^ 8'hC3), "read back");
      end
      acc(1'b0, 1'b0, 16'h07FF);
      chk(acc_onchip_r === 1'b1, "below boundary");
      acc(1'b0, 1'b1, 16'h1256);
      chk(hoen === 1'b1 && acc_onchip_r === 1'b0, "no bank");
    end
  endtask
  task t_bank;
    begin
      wcfg(8'h0B);
      acc(1'b0, 1'b1, 16'h3542);
      chk(hb === 8'h35 && hoen === 1'b0 && hi === 1, "bank");
      acc(1'b0, 1'b1, 16'h0042);
      chk(acc_onchip_r === 1'b1, "bank on-chip");
    end
  endtask
  task t_ext;
    begin
      wcfg(8'h0F);
      acc(1'b1, 1'b0, 16'h0005);
      chk(acc_onchip_r === 1'b0 && cyc === 7 && hi === 1, "ext");
      chk(bz === 6 && acc_busy_r === 1'b0, "busy span");
    end
  endtask
  task t_midchange;
    begin
      wcfg(8'h07);
      fork
        acc(1'b1, 1'b0, 16'h2A00);
        begin
          repeat (3) @(posedge clock);
          wcfg(8'h04);
        end
      join
      chk(hi === 4 && cyc === 13, "config kept");
      chk(bz === 12, "busy kept");
    end
  endtask
  initial
  begin
    {resetn, sfr_wr, acc_req, acc_we, acc_8bit} = 5'h00;
    {sfr_addr, sfr_wdata, acc_wdata} = 24'h000000;
    acc_addr = 16'h0000;
    external_data_ram_page_select = 8'h35;
    port_latch_high = 8'h77;
    num_errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_reg;
    t_onchip;
    t_split;
    t_bank;
    t_ext;
    t_midchange;
    summarize;
  end
endmodule // test_muxed_external_memory_interface
`default_nettype wire
